// ===== rtl/pcu_privilege_check_unit.sv
// Privilege and descriptor type checking unit with register slave
// Contract
// - Four levels 0..3; lower number means more trusted everywhere.
// - Current level is the low two bits of the code segment register.
// - Level stays fixed within a segment; changes via gate transfer, return or task switch.
// - Task switch sets level from the incoming task's code segment.
// - Descriptor usable only if requester level <= descriptor level.
// - Requested level is selector bits 1:0; effective is max with current.
// - Data register loads need data or readable code, else fault 13.
// - Data load faults 13 when descriptor level below effective level.
// - Readable conforming code skips the data privilege check.
// - Passing data load on absent descriptor gives fault 11.
// - Stack load needs writable data, levels equal current, else 13.
// - Absent stack descriptor gives fault 12, not 11.
// - Operation and descriptor type mismatch on code loads gives 13.
// - Direct transfer: nonconforming equal level, conforming level <= current.
// - Direct transfer requires requested level <= current level.
// - Return targets level >= current; popped requested level becomes current.
// - Return changing level pops the outer stack pointer afterwards.
// - Task segment below current level faults 13; valid one switches.
// - Gate level below current level gives fault 13.
// - Gate target level must be <= current; becomes new current level.
// - Gate naming a task segment starts a task switch.
// - Call gates global/local, trap/int gates interrupt table, task global.
// - Interrupt return: nested flag 1 switches task, 0 returns in task.
// - Faults carry selector error code, zero when none applies.
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
module pcu_privilege_check_unit
    import pcu_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    // Check request from execution logic
    input  wire logic        i_chk_req,
    input  wire pcu_op_t     i_chk_op,
    input  wire logic [15:0] i_sel,
    input  wire logic [7:0]  i_desc_access,
    input  wire logic [15:0] i_gate_dest_sel,
    input  wire logic [7:0]  i_dest_access,
    input  wire logic        i_nested_task_flag,
    output logic             o_chk_done,
    output logic             o_fault,
    output logic [7:0]       o_fault_vec,
    output logic [15:0]      o_err_code,
    output logic             o_task_switch,
    output logic [15:0]      o_task_sel,
    output logic             o_pop_outer_sp,
    output logic [1:0]       o_current_priv_level,
    output logic [15:0]      o_code_seg_reg,
    output logic [15:0]      o_data_seg_reg,
    output logic [15:0]      o_extra_data_seg_reg,
    output logic [15:0]      o_stack_seg_reg,
    // Avalon-MM slave
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] cs_r, ds_r, es_r, ss_r;
    logic        done_r, fault_r, tsw_r, pop_r, sticky_r, en_r, ack_r;
    logic [7:0]  vec_r, fcnt_r;
    logic [15:0] err_r, tsel_r;
    logic [31:0] rdata_r;

    // Check results
    logic        fault_nxt, tsw_nxt, pop_nxt;
    logic [7:0]  vec_nxt;
    logic [15:0] err_nxt, tsel_nxt, cs_nxt;

    // ------------------------------------------------------------------
    // Descriptor decode
    // ------------------------------------------------------------------
    logic [1:0] current_priv_level, requested_priv_level, effective_priv_level, descriptor_priv_level, ddpl;
    logic       pres, is_seg, is_code, conf, rdwr, local_tbl;
    logic       d_pres, d_code;
    logic [3:0] typ;
    logic [15:0] err_sel, err_dst;

    assign current_priv_level       = cs_r[1:0];
    assign requested_priv_level       = i_sel[1:0];
    assign effective_priv_level       = (requested_priv_level > current_priv_level) ? requested_priv_level : current_priv_level;
    assign descriptor_priv_level       = i_desc_access[PCU_ACC_DPL_HI:PCU_ACC_DPL_LO];
    assign pres      = i_desc_access[PCU_ACC_P_BIT];
    assign is_seg    = i_desc_access[PCU_ACC_S_BIT];
    assign typ       = i_desc_access[3:0];
    assign is_code   = is_seg & i_desc_access[PCU_ACC_EXEC_BIT];
    assign conf      = i_desc_access[PCU_ACC_CONF_BIT];
    assign rdwr      = i_desc_access[PCU_ACC_RW_BIT];
    assign local_tbl = i_sel[PCU_SEL_TI_BIT];
    assign ddpl      = i_dest_access[PCU_ACC_DPL_HI:PCU_ACC_DPL_LO];
    assign d_pres    = i_dest_access[PCU_ACC_P_BIT];
    assign d_code    = i_dest_access[PCU_ACC_S_BIT]
                     & i_dest_access[PCU_ACC_EXEC_BIT];
    // Error code names the selector without its level bits
    assign err_sel   = {i_sel[15:2], 2'h0};
    assign err_dst   = {i_gate_dest_sel[15:2], 2'h0};

    // ------------------------------------------------------------------
    // Check logic
    // ------------------------------------------------------------------
    always_comb begin
        fault_nxt = 1'b0;
        vec_nxt   = PCU_VEC_NONE;
        err_nxt   = PCU_SEG_RST;
        tsw_nxt   = 1'b0;
        tsel_nxt  = PCU_SEG_RST;
        pop_nxt   = 1'b0;
        cs_nxt    = cs_r;
        unique case (i_chk_op)
            PCU_OP_LOAD_DATA, PCU_OP_LOAD_EXTRA: begin
                if (!is_seg || (is_code && !rdwr)) begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_GPROT;
                    err_nxt   = err_sel;
                end else if (!(is_code && conf) && descriptor_priv_level < effective_priv_level) begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_GPROT;
                    err_nxt   = err_sel;
                end else if (!pres) begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_NP;
                    err_nxt   = err_sel;
                end
            end
            PCU_OP_LOAD_STACK: begin
                if (!is_seg || is_code || !rdwr
                    || descriptor_priv_level != current_priv_level || requested_priv_level != current_priv_level) begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_GPROT;
                    err_nxt   = err_sel;
                end else if (!pres) begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_STACK;
                    err_nxt   = err_sel;
                end
            end
            PCU_OP_JUMP, PCU_OP_CALL: begin
                if (is_seg) begin
                    if (!is_code
                        || (conf ? descriptor_priv_level > current_priv_level : descriptor_priv_level != current_priv_level)
                        || requested_priv_level > current_priv_level) begin
                        fault_nxt = 1'b1;
                        vec_nxt   = PCU_VEC_GPROT;
                        err_nxt   = err_sel;
                    end else if (!pres) begin
                        fault_nxt = 1'b1;
                        vec_nxt   = PCU_VEC_NP;
                        err_nxt   = err_sel;
                    end else begin
                        cs_nxt = {i_sel[15:2], current_priv_level};
                    end
                end else if (typ == PCU_TYP_TSS) begin
                    if (local_tbl || descriptor_priv_level < current_priv_level) begin
                        fault_nxt = 1'b1;
                        vec_nxt   = PCU_VEC_GPROT;
                        err_nxt   = err_sel;
                    end else if (!pres) begin
                        fault_nxt = 1'b1;
                        vec_nxt   = PCU_VEC_NP;
                        err_nxt   = err_sel;
                    end else begin
                        tsw_nxt  = 1'b1;
                        tsel_nxt = i_sel;
                    end
                end else if (typ == PCU_TYP_TASK_GATE) begin
                    if (descriptor_priv_level < current_priv_level) begin
                        fault_nxt = 1'b1;
                        vec_nxt   = PCU_VEC_GPROT;
                        err_nxt   = err_sel;
                    end else if (!pres) begin
                        fault_nxt = 1'b1;
                        vec_nxt   = PCU_VEC_NP;
                        err_nxt   = err_sel;
                    end else begin
                        tsw_nxt  = 1'b1;
                        tsel_nxt = i_gate_dest_sel;
                    end
                end else if (typ == PCU_TYP_CALL_GATE
                             && i_chk_op == PCU_OP_CALL) begin
                    if (descriptor_priv_level < current_priv_level) begin
                        fault_nxt = 1'b1;
                        vec_nxt   = PCU_VEC_GPROT;
                        err_nxt   = err_sel;
                    end else if (!pres) begin
                        fault_nxt = 1'b1;
                        vec_nxt   = PCU_VEC_NP;
                        err_nxt   = err_sel;
                    end else if (!d_code || ddpl > current_priv_level) begin
                        fault_nxt = 1'b1;
                        vec_nxt   = PCU_VEC_GPROT;
                        err_nxt   = err_dst;
                    end else if (!d_pres) begin
                        fault_nxt = 1'b1;
                        vec_nxt   = PCU_VEC_NP;
                        err_nxt   = err_dst;
                    end else begin
                        cs_nxt = {i_gate_dest_sel[15:2], ddpl};
                    end
                end else begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_GPROT;
                    err_nxt   = err_sel;
                end
            end
            PCU_OP_RETURN, PCU_OP_INT_RETURN: begin
                if (i_chk_op == PCU_OP_INT_RETURN
                    && i_nested_task_flag) begin
                    if (is_seg || (typ != PCU_TYP_TASK_GATE
                                   && typ != PCU_TYP_TSS_BUSY)) begin
                        fault_nxt = 1'b1;
                        vec_nxt   = PCU_VEC_GPROT;
                        err_nxt   = err_sel;
                    end else if (!pres) begin
                        fault_nxt = 1'b1;
                        vec_nxt   = PCU_VEC_NP;
                        err_nxt   = err_sel;
                    end else begin
                        tsw_nxt  = 1'b1;
                        tsel_nxt = i_sel;
                    end
                end else if (!is_code || descriptor_priv_level < current_priv_level
                             || requested_priv_level < current_priv_level) begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_GPROT;
                    err_nxt   = err_sel;
                end else if (!pres) begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_NP;
                    err_nxt   = err_sel;
                end else begin
                    cs_nxt  = i_sel;
                    pop_nxt = (requested_priv_level != current_priv_level);
                end
            end
            PCU_OP_INTERRUPT: begin
                // Interrupt table holds only task, interrupt and trap gates
                if (is_seg || (typ != PCU_TYP_TASK_GATE
                               && typ != PCU_TYP_INT_GATE
                               && typ != PCU_TYP_TRAP_GATE)
                    || descriptor_priv_level < current_priv_level) begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_GPROT;
                    err_nxt   = err_sel;
                end else if (!pres) begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_NP;
                    err_nxt   = err_sel;
                end else if (typ == PCU_TYP_TASK_GATE) begin
                    tsw_nxt  = 1'b1;
                    tsel_nxt = i_gate_dest_sel;
                end else if (!d_code || ddpl > current_priv_level) begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_GPROT;
                    err_nxt   = err_dst;
                end else if (!d_pres) begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_NP;
                    err_nxt   = err_dst;
                end else begin
                    cs_nxt = {i_gate_dest_sel[15:2], ddpl};
                end
            end
            PCU_OP_TASK_ENTER: begin
                // Incoming task runs at its code segment's level
                if (!is_code) begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_GPROT;
                    err_nxt   = err_sel;
                end else if (!pres) begin
                    fault_nxt = 1'b1;
                    vec_nxt   = PCU_VEC_NP;
                    err_nxt   = err_sel;
                end else begin
                    cs_nxt = {i_sel[15:2], descriptor_priv_level};
                end
            end
            default: begin
                fault_nxt = 1'b1;
                vec_nxt   = PCU_VEC_GPROT;
                err_nxt   = PCU_SEG_RST;
            end
        endcase
        // Checking disabled: every load passes, levels untouched
        if (!en_r) begin
            fault_nxt = 1'b0;
            vec_nxt   = PCU_VEC_NONE;
            err_nxt   = PCU_SEG_RST;
            tsw_nxt   = 1'b0;
            pop_nxt   = 1'b0;
            cs_nxt    = (i_chk_op == PCU_OP_JUMP || i_chk_op == PCU_OP_CALL
                         || i_chk_op == PCU_OP_RETURN
                         || i_chk_op == PCU_OP_INT_RETURN
                         || i_chk_op == PCU_OP_TASK_ENTER)
                        ? {i_sel[15:2], current_priv_level} : cs_r;
        end
    end

    // ------------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            done_r <= 1'b0;
            fault_r <= 1'b0;
            vec_r  <= PCU_VEC_NONE;
            err_r  <= PCU_SEG_RST;
            tsw_r  <= 1'b0;
            tsel_r <= PCU_SEG_RST;
            pop_r  <= 1'b0;
        end else begin
            done_r  <= i_chk_req;
            fault_r <= i_chk_req & fault_nxt;
            tsw_r   <= i_chk_req & tsw_nxt;
            pop_r   <= i_chk_req & ~fault_nxt & pop_nxt;
            if (i_chk_req) begin
                vec_r  <= vec_nxt;
                err_r  <= err_nxt;
                tsel_r <= tsel_nxt;
            end
        end
    end

    // Segment registers commit only after a clean check
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            cs_r <= PCU_SEG_RST;
            ds_r <= PCU_SEG_RST;
            es_r <= PCU_SEG_RST;
            ss_r <= PCU_SEG_RST;
        end else if (i_chk_req && !fault_nxt) begin
            cs_r <= cs_nxt;
            if (i_chk_op == PCU_OP_LOAD_DATA) begin
                ds_r <= i_sel;
            end
            if (i_chk_op == PCU_OP_LOAD_EXTRA) begin
                es_r <= i_sel;
            end
            if (i_chk_op == PCU_OP_LOAD_STACK) begin
                ss_r <= i_sel;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------------
    logic acc;
    logic wr_ctrl, wr_status;
    assign acc       = (i_avs_read | i_avs_write) & ~ack_r;
    assign wr_ctrl   = acc & i_avs_write & i_avs_byteenable[0]
                     & (i_avs_address == PCU_OFS_CTRL);
    assign wr_status = acc & i_avs_write & i_avs_byteenable[0]
                     & (i_avs_address == PCU_OFS_STATUS);

    // One wait state: answer on the second edge of a request
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= acc;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            en_r <= PCU_CTRL_EN_RST;
        end else if (wr_ctrl) begin
            en_r <= i_avs_writedata[PCU_CTRL_EN_BIT];
        end
    end

    // Fault during a clear keeps the flag: set wins
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            sticky_r <= 1'b0;
        end else if (i_chk_req && fault_nxt) begin
            sticky_r <= 1'b1;
        end else if (wr_status && i_avs_writedata[PCU_ST_STICKY_BIT]) begin
            sticky_r <= 1'b0;
        end
    end

    // Counter saturates rather than wrapping to a misleading zero
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            fcnt_r <= PCU_FCNT_RST;
        end else if (i_chk_req && fault_nxt && fcnt_r != 8'hff) begin
            fcnt_r <= fcnt_r + 8'h01;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rdata_r <= 32'h0000_0000;
        end else if (acc && i_avs_read) begin
            unique case (i_avs_address)
                PCU_OFS_CTRL:   rdata_r <= {31'h0, en_r};
                PCU_OFS_STATUS: rdata_r <= {16'h0, vec_r, 5'h0,
                                            sticky_r, current_priv_level};
                PCU_OFS_ERR:    rdata_r <= {16'h0, err_r};
                PCU_OFS_CS:     rdata_r <= {16'h0, cs_r};
                PCU_OFS_DS:     rdata_r <= {16'h0, ds_r};
                PCU_OFS_ES:     rdata_r <= {16'h0, es_r};
                PCU_OFS_SS:     rdata_r <= {16'h0, ss_r};
                PCU_OFS_FCNT:   rdata_r <= {24'h0, fcnt_r};
                default:        rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_avs_waitrequest    = acc;
    assign o_avs_readdata       = rdata_r;
    assign o_chk_done           = done_r;
    assign o_fault              = fault_r;
    assign o_fault_vec          = vec_r;
    assign o_err_code           = err_r;
    assign o_task_switch        = tsw_r;
    assign o_task_sel           = tsel_r;
    assign o_pop_outer_sp       = pop_r;
    assign o_current_priv_level = current_priv_level;
    assign o_code_seg_reg       = cs_r;
    assign o_data_seg_reg       = ds_r;
    assign o_extra_data_seg_reg = es_r;
    assign o_stack_seg_reg      = ss_r;

endmodule // pcu_privilege_check_unit

// ===== rtl/pcu_pkg.sv
// Package: constants and types of the privilege check unit
package pcu_pkg;

    // ------------------------------------------------------------------
    // Privilege levels
    // ------------------------------------------------------------------
    localparam logic [1:0] PCU_LVL_MOST  = 2'h0;
    localparam logic [1:0] PCU_LVL_LEAST = 2'h3;

    // ------------------------------------------------------------------
    // Selector and access byte layout
    // ------------------------------------------------------------------
    localparam int PCU_SEL_TI_BIT   = 2;
    localparam int PCU_ACC_P_BIT    = 7;
    localparam int PCU_ACC_DPL_HI   = 6;
    localparam int PCU_ACC_DPL_LO   = 5;
    localparam int PCU_ACC_S_BIT    = 4;
    localparam int PCU_ACC_EXEC_BIT = 3;
    localparam int PCU_ACC_CONF_BIT = 2;
    localparam int PCU_ACC_RW_BIT   = 1;

    // System descriptor type codes
    localparam logic [3:0] PCU_TYP_TSS       = 4'h1;
    localparam logic [3:0] PCU_TYP_TSS_BUSY  = 4'h3;
    localparam logic [3:0] PCU_TYP_CALL_GATE = 4'h4;
    localparam logic [3:0] PCU_TYP_TASK_GATE = 4'h5;
    localparam logic [3:0] PCU_TYP_INT_GATE  = 4'h6;
    localparam logic [3:0] PCU_TYP_TRAP_GATE = 4'h7;

    // Fault vectors
    localparam logic [7:0] PCU_VEC_NONE   = 8'h00;
    localparam logic [7:0] PCU_VEC_NP     = 8'h0b;
    localparam logic [7:0] PCU_VEC_STACK  = 8'h0c;
    localparam logic [7:0] PCU_VEC_GPROT  = 8'h0d;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [4:0] PCU_OFS_CTRL   = 5'h00;
    localparam logic [4:0] PCU_OFS_STATUS = 5'h04;
    localparam logic [4:0] PCU_OFS_ERR    = 5'h08;
    localparam logic [4:0] PCU_OFS_CS     = 5'h0c;
    localparam logic [4:0] PCU_OFS_DS     = 5'h10;
    localparam logic [4:0] PCU_OFS_ES     = 5'h14;
    localparam logic [4:0] PCU_OFS_SS     = 5'h18;
    localparam logic [4:0] PCU_OFS_FCNT   = 5'h1c;

    localparam int         PCU_CTRL_EN_BIT   = 0;
    localparam logic       PCU_CTRL_EN_RST   = 1'b1;
    localparam int         PCU_ST_STICKY_BIT = 2;
    localparam int         PCU_ST_VEC_LO     = 8;
    localparam logic [15:0] PCU_SEG_RST      = 16'h0000;
    localparam logic [7:0]  PCU_FCNT_RST     = 8'h00;

    // ------------------------------------------------------------------
    // Check operations
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PCU_OP_LOAD_DATA,
        PCU_OP_LOAD_EXTRA,
        PCU_OP_LOAD_STACK,
        PCU_OP_JUMP,
        PCU_OP_CALL,
        PCU_OP_RETURN,
        PCU_OP_INT_RETURN,
        PCU_OP_INTERRUPT,
        PCU_OP_TASK_ENTER
    } pcu_op_t;

endpackage : pcu_pkg

// ===== testbench/pcu_desc_model.sv
// Descriptor fetch model: access byte per table index
module pcu_desc_model (
    input  wire logic [15:0] i_sel,
    output logic      [7:0]  o_access
);
    timeunit 1ns;
    timeprecision 1ps;
    // 3 absent data, 5 level 0 call gate, 6 level 0 task segment
    localparam logic [7:0] TBL [8] = '{8'h93, 8'hf3, 8'h98, 8'h13,
                                       8'h9e, 8'h84, 8'h81, 8'hfa};
    assign o_access = TBL[i_sel[5:3]];
endmodule // pcu_desc_model

// ===== testbench/pcu_chk_monitor.sv
// Checker: concurrent assertions on the unit's ports
module pcu_chk_monitor
    import pcu_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_srst,
    input wire logic        i_chk_req,
    input wire logic        i_avs_read,
    input wire logic        o_chk_done,
    input wire logic        o_fault,
    input wire logic        o_pop_outer_sp,
    input wire logic        o_avs_waitrequest,
    input wire logic [7:0]  o_fault_vec,
    input wire logic [15:0] o_err_code,
    input wire logic [1:0]  o_current_priv_level,
    input wire logic [15:0] o_code_seg_reg,
    input wire logic [15:0] o_data_seg_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    sequence s_acc; o_avs_waitrequest ##1 !o_avs_waitrequest; endsequence
    property p_bus; $rose(i_avs_read) |-> s_acc; endproperty
    a_bus: assert property (p_bus) else $error("bad wait");
    property p_done; i_chk_req |=> o_chk_done; endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_lvl; o_current_priv_level == o_code_seg_reg[1:0]; endproperty
    a_lvl: assert property (p_lvl) else $error("bad level");
    property p_keep; !o_chk_done |-> $stable(o_current_priv_level);
    endproperty
    a_keep: assert property (p_keep) else $error("level moved");
    property p_safe; o_fault |-> $stable(o_code_seg_reg)
        && $stable(o_data_seg_reg); endproperty
    a_safe: assert property (p_safe) else $error("fault wrote");
    property p_vec; o_chk_done |-> o_fault == (o_fault_vec != PCU_VEC_NONE);
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_err; o_chk_done && !o_fault |-> o_err_code == 16'h0000;
    endproperty
    a_err: assert property (p_err) else $error("bad code");
    property p_pop; o_pop_outer_sp |-> o_chk_done && !o_fault
        && o_current_priv_level != $past(o_current_priv_level); endproperty
    a_pop: assert property (p_pop) else $error("bad pop");
endmodule // pcu_chk_monitor

// ===== testbench/tb.sv
// Testbench: descriptor checks and register access on the unit
module tb import pcu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys, i_srst, i_chk_req, i_nested_task_flag;
    logic i_avs_read, i_avs_write, o_chk_done, o_fault;
    logic o_task_switch, o_pop_outer_sp, o_avs_waitrequest;
    pcu_op_t i_chk_op;
    logic [15:0] i_sel, i_gate_dest_sel, o_err_code, o_task_sel;
    logic [15:0] o_code_seg_reg, o_data_seg_reg;
    logic [15:0] o_extra_data_seg_reg, o_stack_seg_reg;
    logic [7:0] i_desc_access, i_dest_access, o_fault_vec;
    logic [4:0] i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata, q;
    logic [3:0] i_avs_byteenable;
    logic [1:0] o_current_priv_level;
    int num_errors, compares;
    pcu_privilege_check_unit dut (.*);
    pcu_desc_model m_seg (.i_sel(i_sel), .o_access(i_desc_access));
    pcu_desc_model m_dst (.i_sel(i_gate_dest_sel), .o_access(i_dest_access));
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    task automatic stop_test;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Fault vector is read on the done cycle
    task automatic chk(input pcu_op_t op, input logic [15:0] s,
                       input logic [7:0] v);
        @(posedge i_clk_sys);
        i_chk_req <= 1'b1;
        i_chk_op <= op;
        i_sel <= s;
        @(posedge i_clk_sys);
        i_chk_req <= 1'b0;
        @(negedge i_clk_sys);
        cmp({24'h0, o_fault_vec}, {24'h0, v});
        cmp({16'h0, o_err_code},
            (v == PCU_VEC_NONE) ? 32'h0 : {16'h0, s[15:2], 2'h0});
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge i_clk_sys);
        i_avs_read <= !w;
        i_avs_write <= w;
        i_avs_address <= a;
        i_avs_writedata <= d;
        do @(posedge i_clk_sys); while (o_avs_waitrequest);
        q = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    initial begin
        {i_chk_req, i_avs_read, i_avs_write, i_nested_task_flag} = '0;
        i_chk_op = PCU_OP_LOAD_DATA;
        {i_sel, i_gate_dest_sel, i_avs_writedata, i_avs_address} = '0;
        i_avs_byteenable = 4'hf;
        i_srst = 1'b1;
        repeat (16) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        chk(PCU_OP_LOAD_DATA, 16'h0001, PCU_VEC_GPROT);
        chk(PCU_OP_LOAD_EXTRA, 16'h0010, PCU_VEC_GPROT);
        chk(PCU_OP_LOAD_DATA, 16'h0028, PCU_VEC_GPROT);
        chk(PCU_OP_LOAD_DATA, 16'h0018, PCU_VEC_NP);
        chk(PCU_OP_LOAD_STACK, 16'h0018, PCU_VEC_STACK);
        chk(PCU_OP_LOAD_STACK, 16'h0008, PCU_VEC_GPROT);
        chk(PCU_OP_JUMP, 16'h0028, PCU_VEC_GPROT);
        chk(PCU_OP_JUMP, 16'h0021, PCU_VEC_GPROT);
        chk(PCU_OP_JUMP, 16'h0020, PCU_VEC_NONE);
        chk(PCU_OP_LOAD_DATA, 16'h000b, PCU_VEC_NONE);
        cmp({16'h0, o_data_seg_reg}, 32'h0000_000b);
        chk(PCU_OP_RETURN, 16'h003b, PCU_VEC_NONE);
        cmp({30'h0, o_current_priv_level}, 32'h0000_0003);
        chk(PCU_OP_LOAD_DATA, 16'h0023, PCU_VEC_NONE);
        chk(PCU_OP_LOAD_EXTRA, 16'h0000, PCU_VEC_GPROT);
        chk(PCU_OP_JUMP, 16'h0030, PCU_VEC_GPROT);
        chk(PCU_OP_CALL, 16'h0028, PCU_VEC_GPROT);
        bus(1'b0, PCU_OFS_STATUS, 32'h0);
        cmp(q, 32'h0000_0d07);
        bus(1'b1, PCU_OFS_STATUS, 32'h0000_0004);
        bus(1'b0, PCU_OFS_STATUS, 32'h0);
        cmp(q, 32'h0000_0d03);
        chk(PCU_OP_TASK_ENTER, 16'h0020, PCU_VEC_NONE);
        cmp({16'h0, o_code_seg_reg}, 32'h0000_0020);
        chk(PCU_OP_JUMP, 16'h0030, PCU_VEC_NONE);
        cmp({15'h0, o_task_switch, o_task_sel}, 32'h0001_0030);
        chk(PCU_OP_INTERRUPT, 16'h0028, PCU_VEC_GPROT);
        chk(PCU_OP_INT_RETURN, 16'h003b, PCU_VEC_NONE);
        cmp({31'h0, o_pop_outer_sp}, 32'h0000_0001);
        chk(PCU_OP_LOAD_EXTRA, 16'h000b, PCU_VEC_NONE);
        chk(PCU_OP_LOAD_STACK, 16'h000b, PCU_VEC_NONE);
        cmp({o_extra_data_seg_reg, o_stack_seg_reg}, 32'h000b_000b);
        stop_test;
    end
    initial begin
        repeat (2000) @(posedge i_clk_sys);
        num_errors++;
        stop_test;
    end
endmodule // tb
bind pcu_privilege_check_unit pcu_chk_monitor u_mon (.*);
